/* File: qnm_core.sv */
// Oscillator core: increment, accumulator, sine/cosine, 31-cycle pipe
`default_nettype none
`include "qnm_consts.svh"
// Operation
// - Host holds mode low for fixed amplitude
// - Bus captured while load enable low; the amplitude field is taken on every non-strobe cycle regardless
// - 34-bit increment, fout = inc*fclk/2^34
// - AM mode scales outputs by upper 16
// - AM mode loads low 18 into upper
// - AM mode keeps low 16 increment bits unchanged
// - AM strobe loads all 34, amplitude held
// - Strobe cycle upper bits are increment
// - AM: reset first, first sample after 31
// - Increment change visible after 31 cycles
// - Full word accepted any cycle, no buffering
// - Relative jump: one cycle jump increment
// - Strobe without AM sets absolute phase
// - Reset jumps to zero phase, synchronised
// - Unused low amplitude bits tied low
// - Reset clears accumulator and increment, pipelined
// - Valid flag delayed by pipeline latency
// - Jumps and resets take effect after pipe
// - Output enable high gives high impedance; the core only drops the matching oe flag and has no tristate
module qnm_core #(
   parameter int LATENCY = `QNM_LATENCY
) (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   // Link to host logic
   qnm_if.dev        lnk
);
   import qnm_pkg::*;

   // Front stage plus pipe plus output flop make up the latency
   localparam int ACC_STAGES = 2;
   localparam int PIPE_LEN   = LATENCY - ACC_STAGES;
   localparam int LUT_N      = 256;

   // Phase word and accumulator
   qnm_word_t   inc_ff;
   qnm_word_t   nxt_inc;
   qnm_word_t   acc_ff;
   qnm_word_t   nxt_acc;

   // Reset request synchroniser
   logic        rst_s1_ff;
   logic        rst_s2_ff;

   // Absolute jump request and target
   logic        jump_ff;
   logic        nxt_jump;
   qnm_word_t   jval_ff;

   // Front stage of the side band
   logic signed [`QNM_AMP_W-1:0] amp_ff;
   logic        am_ff;
   logic        vld_ff;

   // Delay line, one entry per pipe stage
   logic [15:0] addr_pipe_ff [PIPE_LEN];
   logic [15:0] amp_pipe_ff  [PIPE_LEN];
   logic        am_pipe_ff   [PIPE_LEN];
   logic        vld_pipe_ff  [PIPE_LEN];

   // Output samples and flag
   qnm_sample_t sin_ff;
   qnm_sample_t cos_ff;
   logic        valid_flag_out_ff;

   // One sine point per top address byte, 16-bit signed
   function automatic qnm_sample_t sin_of(input logic [7:0] idx);
      real a;
      a = $sin(6.283185307179586 * real'(idx) / real'(LUT_N));
      return qnm_sample_t'($rtoi(a * 32767.0));
   endfunction : sin_of

   // Signed 16x16 scale, keeps top of product
   function automatic qnm_sample_t scale(input qnm_sample_t s,
                                         input logic signed [15:0] g);
      logic signed [31:0] p;
      p = s * g;
      return qnm_sample_t'(p[30:15]);
   endfunction : scale

   // Table filled at elaboration; cosine reads it a quarter ahead
   wire qnm_sample_t sin_lut [LUT_N];
   for (genvar k = 0; k < LUT_N; k++) begin : g_lut
      assign sin_lut[k] = sin_of(8'(k));
   end

   // Either reset source, synchronised; acts at the front of the pipe
   wire rst_req  = rst_s2_ff;
   wire am_mode  = (lnk.mode_am == 1'b1);
   wire load     = ~lnk.load_enable_n;
   wire strobe   = lnk.phase_load_strobe & load;

   // Bus fields: amplitude on top, coarse increment below
   wire [`QNM_AMP_W-1:0] bus_amp =
      lnk.input_word_bus[`QNM_WORD_W-1:`QNM_AMP_LSB];
   wire qnm_word_t coarse_inc = {lnk.input_word_bus[`QNM_COARSE_W-1:0],
                                 inc_ff[`QNM_FINE_W-1:0]};

   // Increment select by mode; reset wins over any load
   always_comb begin
      nxt_inc = inc_ff;
      if (load && (!am_mode || strobe)) begin
         nxt_inc = lnk.input_word_bus;
      end else if (load) begin
         nxt_inc = coarse_inc;
      end
      if (!am_mode && strobe) begin
         nxt_inc = inc_ff;
      end
      if (rst_req) begin
         nxt_inc = `QNM_INC_RST;
      end
   end

   // Accumulator, absolute jump or reset
   always_comb begin
      nxt_acc = acc_ff + inc_ff;
      if (jump_ff) begin
         nxt_acc = jval_ff;
      end
      if (rst_req) begin
         nxt_acc = `QNM_ACC_RST;
      end
   end

   // Absolute jump only outside AM; in AM the strobe loads the word
   assign nxt_jump = strobe & ~am_mode;

   // Two flops; phase reset pin and system reset share the path
   always_ff @(posedge clk_sys_i) begin
      rst_s1_ff <= ~rst_n_i | lnk.phase_reset;
      rst_s2_ff <= rst_s1_ff;
   end

   // Phase state
   always_ff @(posedge clk_sys_i) begin
      inc_ff  <= nxt_inc;
      acc_ff  <= nxt_acc;
   end

   // Jump request and its target word
   always_ff @(posedge clk_sys_i) begin
      jump_ff <= nxt_jump;
      jval_ff <= lnk.input_word_bus;
   end

   // Amplitude held over a strobe cycle, reloaded from the bus on every other cycle
   always_ff @(posedge clk_sys_i) begin
      amp_ff  <= strobe ? amp_ff : bus_amp;
      am_ff   <= am_mode;
      vld_ff  <= lnk.valid_flag_in;
   end

   // Pipe entry taken from the adder so phase and flag stay aligned
   always_ff @(posedge clk_sys_i) begin
      addr_pipe_ff[0] <= nxt_acc[`QNM_WORD_W-1 -: 16];
      amp_pipe_ff[0]  <= amp_ff;
      am_pipe_ff[0]   <= am_ff;
      vld_pipe_ff[0]  <= vld_ff;
   end

   // Remaining stages shift once per clock
   for (genvar i = 1; i < PIPE_LEN; i++) begin : g_pipe
      always_ff @(posedge clk_sys_i) begin
         addr_pipe_ff[i] <= addr_pipe_ff[i-1];
         amp_pipe_ff[i]  <= amp_pipe_ff[i-1];
         am_pipe_ff[i]   <= am_pipe_ff[i-1];
         vld_pipe_ff[i]  <= vld_pipe_ff[i-1];
      end
   end

   // Pipe tail: phase, quarter-ahead phase, gain and mode
   wire [15:0] ph_q = addr_pipe_ff[PIPE_LEN-1];
   wire [15:0] ph_c = ph_q + 16'h4000;
   wire qnm_sample_t s_raw = sin_lut[ph_q[15:8]];
   wire qnm_sample_t c_raw = sin_lut[ph_c[15:8]];
   wire logic signed [15:0] g = amp_pipe_ff[PIPE_LEN-1];
   wire am_out = am_pipe_ff[PIPE_LEN-1];

   // Output stage, two's complement samples every clock
   always_ff @(posedge clk_sys_i) begin
      sin_ff  <= am_out ? scale(s_raw, g) : s_raw;
      cos_ff  <= am_out ? scale(c_raw, g) : c_raw;
   end

   // Valid flag forced low while system reset is held
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         valid_flag_out_ff <= 1'b0;
      end else begin
         valid_flag_out_ff <= vld_pipe_ff[PIPE_LEN-1];
      end
   end

   // Sample drivers; no tristate inside, the enable travels instead
   assign lnk.in_phase_wave_out   = sin_ff;
   assign lnk.quadrature_wave_out = cos_ff;

   // Drivers released while their enable is high
   assign lnk.in_phase_wave_oe    = ~lnk.first_wave_enable_n;
   assign lnk.quadrature_wave_oe  = ~lnk.second_wave_enable_n;
   assign lnk.valid_flag_out      = valid_flag_out_ff;
endmodule : qnm_core
`default_nettype wire

/* File: qnm_consts.svh */
// Constants shared by both ends of the quadrature oscillator link
`ifndef QNM_CONSTS_SVH
`define QNM_CONSTS_SVH
`define QNM_WORD_W       34
`define QNM_AMP_W        16
`define QNM_AMP_LSB      18
`define QNM_FINE_W       16
`define QNM_COARSE_W     18
`define QNM_OUT_W        16
`define QNM_LATENCY      31
`define QNM_INC_RST      34'h000000000
`define QNM_ACC_RST      34'h000000000
`endif

/* File: qnm_pkg.sv */
// Types shared by both ends of the quadrature oscillator link
`default_nettype none
`include "qnm_consts.svh"
package qnm_pkg;
   typedef logic [`QNM_WORD_W-1:0] qnm_word_t;
   typedef logic signed [`QNM_OUT_W-1:0] qnm_sample_t;
   typedef enum logic {QNM_MODE_FIXED, QNM_MODE_AM} qnm_mode_t;
endpackage : qnm_pkg
`default_nettype wire

/* File: qnm_if.sv */
// Pin-level link between host logic and the oscillator core
`default_nettype none
interface qnm_if;
   import qnm_pkg::*;
   qnm_word_t   input_word_bus;
   logic        load_enable_n;
   logic        phase_load_strobe;
   logic        phase_reset;
   logic        mode_am;
   logic        valid_flag_in;
   logic        valid_flag_out;
   logic        first_wave_enable_n;
   logic        second_wave_enable_n;
   qnm_sample_t in_phase_wave_out;
   logic        in_phase_wave_oe;
   qnm_sample_t quadrature_wave_out;
   logic        quadrature_wave_oe;
   modport dev (
      input  input_word_bus, load_enable_n, phase_load_strobe,
             phase_reset, mode_am, valid_flag_in,
             first_wave_enable_n, second_wave_enable_n,
      output valid_flag_out, in_phase_wave_out, in_phase_wave_oe,
             quadrature_wave_out, quadrature_wave_oe
   );
   modport host (
      output input_word_bus, load_enable_n, phase_load_strobe,
             phase_reset, mode_am, valid_flag_in,
             first_wave_enable_n, second_wave_enable_n,
      input  valid_flag_out, in_phase_wave_out, in_phase_wave_oe,
             quadrature_wave_out, quadrature_wave_oe
   );
endinterface : qnm_if
`default_nettype wire

/* File: qnm_host.sv */
// Host end: drives words and controls, returns samples to user
`default_nettype none
`include "qnm_consts.svh"
module qnm_host (
   // Clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             rst_n_i,
   // User requests
   input  wire qnm_pkg::qnm_word_t usr_word_i,
   input  wire logic             usr_load_i,
   input  wire logic             usr_strobe_i,
   input  wire logic             usr_am_i,
   input  wire logic             usr_phase_reset_i,
   input  wire logic             usr_valid_i,
   input  wire logic             usr_sin_en_i,
   input  wire logic             usr_cos_en_i,
   // User results
   output logic                  usr_valid_o,
   output qnm_pkg::qnm_sample_t  usr_sin_o,
   output qnm_pkg::qnm_sample_t  usr_cos_o,
   // Link to core
   qnm_if.host                   lnk
);
   import qnm_pkg::*;

   qnm_word_t word_ff;
   logic      load_n_ff, strobe_ff, am_ff, pres_ff, vin_ff;
   logic      sin_en_n_ff, cos_en_n_ff;
   logic      valid_flag_out_ff;
   qnm_sample_t sin_ff, cos_ff;

   // Registered drive of the link; mode low unless AM asked
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         word_ff     <= `QNM_INC_RST;
         load_n_ff   <= 1'b1;
         strobe_ff   <= 1'b0;
         am_ff       <= 1'b0;
         pres_ff     <= 1'b1;
         vin_ff      <= 1'b0;
         sin_en_n_ff <= 1'b1;
         cos_en_n_ff <= 1'b1;
      end else begin
         word_ff     <= usr_word_i;
         load_n_ff   <= ~usr_load_i;
         strobe_ff   <= usr_strobe_i;
         am_ff       <= usr_am_i;
         pres_ff     <= usr_phase_reset_i;
         vin_ff      <= usr_valid_i;
         sin_en_n_ff <= ~usr_sin_en_i;
         cos_en_n_ff <= ~usr_cos_en_i;
      end
   end

   // Samples returned registered; zero when driver released
   always_ff @(posedge clk_sys_i) begin
      valid_flag_out_ff <= rst_n_i & lnk.valid_flag_out;
      sin_ff  <= lnk.in_phase_wave_oe ? lnk.in_phase_wave_out : '0;
      cos_ff  <= lnk.quadrature_wave_oe ? lnk.quadrature_wave_out : '0;
   end

   assign lnk.input_word_bus       = word_ff;
   assign lnk.load_enable_n        = load_n_ff;
   assign lnk.phase_load_strobe    = strobe_ff;
   assign lnk.phase_reset          = pres_ff;
   assign lnk.mode_am              = am_ff;
   assign lnk.valid_flag_in        = vin_ff;
   assign lnk.first_wave_enable_n  = sin_en_n_ff;
   assign lnk.second_wave_enable_n = cos_en_n_ff;
   assign usr_valid_o = valid_flag_out_ff;
   assign usr_sin_o   = sin_ff;
   assign usr_cos_o   = cos_ff;
endmodule : qnm_host
`default_nettype wire

/* File: qnm_chk.sv */
// Link checker for the quadrature oscillator
`default_nettype none
module qnm_chk (
   // Clock and reset
   input wire logic                 clk_sys_i,
   input wire logic                 rst_n_i,
   // Link signals
   input wire qnm_pkg::qnm_word_t   input_word_bus,
   input wire logic                 load_enable_n,
   input wire logic                 phase_load_strobe,
   input wire logic                 mode_am,
   input wire logic                 valid_flag_in,
   input wire logic                 valid_flag_out,
   input wire logic                 first_wave_enable_n,
   input wire logic                 second_wave_enable_n,
   input wire qnm_pkg::qnm_sample_t in_phase_wave_out,
   input wire logic                 in_phase_wave_oe,
   input wire qnm_pkg::qnm_sample_t quadrature_wave_out,
   input wire logic                 quadrature_wave_oe
);
   import qnm_pkg::*;
   logic [7:0] run_ff;
   logic [7:0] amz_ff;
   logic       dirty_ff;
   wire idle_fix = load_enable_n & ~phase_load_strobe & ~mode_am;
   wire amp_zero = mode_am & ~phase_load_strobe
                   & (input_word_bus[33:18] == 16'h0000);
   wire settled  = (run_ff >= 8'h50) & ~dirty_ff;
   // Saturating; a reset clear may wait a full pipe before it lands
   always_ff @(posedge clk_sys_i) begin
      run_ff   <= !rst_n_i ? 8'h00 : run_ff + {7'h00, run_ff != 8'hFF};
      amz_ff   <= !amp_zero ? 8'h00 : amz_ff + {7'h00, amz_ff != 8'hFF};
      dirty_ff <= rst_n_i & (dirty_ff | ~idle_fix);
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   chk_sin_oe_pin: assert property (
      in_phase_wave_oe == !first_wave_enable_n) else $error("sine oe");
   chk_cos_oe_pin: assert property (
      quadrature_wave_oe == !second_wave_enable_n) else $error("cosine oe");
   chk_valid_delay: assert property (
      run_ff >= 8'h28 |-> valid_flag_out == $past(valid_flag_in, 31))
      else $error("valid delay");
   chk_valid_rise: assert property (
      $rose(valid_flag_in) && run_ff >= 8'h28 |-> ##31 valid_flag_out)
      else $error("valid rise");
   chk_reset_sine: assert property (
      settled |-> in_phase_wave_out == 16'sh0000) else $error("reset sine");
   chk_reset_cos: assert property (
      settled |-> quadrature_wave_out > 16'sh0000) else $error("reset cos");
   chk_am_zero_sin: assert property (
      amz_ff >= 8'h50 |-> in_phase_wave_out == 16'sh0000) else $error("am sin");
   chk_am_zero_cos: assert property (
      amz_ff >= 8'h50 |-> quadrature_wave_out == 16'sh0000) else $error("am cos");
   cov_valid: cover property ($rose(valid_flag_out));
   cov_settled: cover property (settled);
   cov_am_zero: cover property (amz_ff >= 8'h50);
endmodule : qnm_chk
`default_nettype wire

/* File: quadrature_nco_modulator_tb.sv */
// Self-checking bench joining host and core ends
`default_nettype none
module quadrature_nco_modulator_tb;
   import qnm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, rst_n = 0, ld = 0, st = 0, am = 0, vld = 0;
   logic sin_en = 1, cos_en = 1, v_o, pres = 0;
   qnm_word_t   word = '0;
   qnm_sample_t sin_o, cos_o, s0;
   int          err_count = 0, check_count = 0, n;
   qnm_if lnk_if();
   qnm_host qnm_host_i (.clk_sys_i(clk_sys), .rst_n_i(rst_n),
      .usr_word_i(word), .usr_load_i(ld), .usr_strobe_i(st), .usr_am_i(am),
      .usr_phase_reset_i(pres), .usr_valid_i(vld), .usr_sin_en_i(sin_en),
      .usr_cos_en_i(cos_en), .usr_valid_o(v_o), .usr_sin_o(sin_o),
      .usr_cos_o(cos_o), .lnk(lnk_if.host));
   qnm_core #(.LATENCY(31)) qnm_core_i (.clk_sys_i(clk_sys),
      .rst_n_i(rst_n), .lnk(lnk_if.dev));
   qnm_chk qnm_chk_i (.clk_sys_i(clk_sys), .rst_n_i(rst_n),
      .input_word_bus(lnk_if.input_word_bus),
      .load_enable_n(lnk_if.load_enable_n),
      .phase_load_strobe(lnk_if.phase_load_strobe),
      .mode_am(lnk_if.mode_am), .valid_flag_in(lnk_if.valid_flag_in),
      .valid_flag_out(lnk_if.valid_flag_out),
      .first_wave_enable_n(lnk_if.first_wave_enable_n),
      .second_wave_enable_n(lnk_if.second_wave_enable_n),
      .in_phase_wave_out(lnk_if.in_phase_wave_out),
      .in_phase_wave_oe(lnk_if.in_phase_wave_oe),
      .quadrature_wave_out(lnk_if.quadrature_wave_out),
      .quadrature_wave_oe(lnk_if.quadrature_wave_oe));
   // 100 MHz clock
   always #5 clk_sys = ~clk_sys;
   // One bus word per edge; a request lasts until the next send
   task automatic send(input qnm_word_t w, input logic l, s, a);
      @(posedge clk_sys);
      word <= w;
      ld <= l;
      st <= s;
      am <= a;
   endtask : send
   task automatic wait_clk(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask : wait_clk
   task automatic do_reset();
      @(posedge clk_sys);
      rst_n <= 0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1;
   endtask : do_reset
   task automatic cmp_sample(input qnm_sample_t got, exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_sample
   task automatic cmp_flag(input logic got, exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_flag
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   // Tests take under 800 cycles
   initial begin
      repeat (3000) @(posedge clk_sys);
      err_count++;
      conclude();
   end
   initial begin
      do_reset();
      wait_clk(90);
      cmp_sample(sin_o, 16'sh0000);
      cmp_flag(cos_o[15], 1'b0);
      // Valid pulse: host in, 31-cycle pipe, host out
      @(posedge clk_sys);
      vld <= 1;
      for (n = 1; n < 60; n++) begin
         @(posedge clk_sys);
         vld <= 0;
         #1;
         if (v_o === 1'b1) break;
      end
      cmp_sample(qnm_sample_t'(n), 16'sh0021);
      send(34'h100000000, 1, 1, 0);
      send(34'h000000000, 0, 0, 0);
      wait_clk(40);
      cmp_flag(sin_o[15], 1'b0);
      cmp_flag(sin_o != 16'sh0000, 1'b1);
      @(posedge clk_sys) sin_en <= 0;
      wait_clk(4);
      cmp_sample(sin_o, 16'sh0000);
      @(posedge clk_sys) sin_en <= 1;
      cos_en <= 0;
      wait_clk(4);
      cmp_sample(cos_o, 16'sh0000);
      @(posedge clk_sys) cos_en <= 1;
      send(34'h200000000, 1, 1, 0);
      send(34'h000000000, 0, 0, 0);
      wait_clk(40);
      cmp_flag(cos_o[15], 1'b1);
      // Increment of 2^30 gives a 16-cycle period
      // Phase reset pulse clears phase and increment
      @(posedge clk_sys) pres <= 1;
      @(posedge clk_sys) pres <= 0;
      wait_clk(40);
      cmp_sample(sin_o, 16'sh0000);
      cmp_flag(cos_o[15], 1'b0);
      // New increment shows 31 core cycles plus two host flops later
      send(34'h040000000, 1, 0, 0);
      for (n = 1; n < 60; n++) begin
         @(posedge clk_sys);
         ld <= 0;
         #1;
         if (sin_o !== 16'sh0000) break;
      end
      cmp_sample(qnm_sample_t'(n), 16'sh0021);
      wait_clk(60);
      s0 = sin_o;
      wait_clk(16);
      cmp_sample(sin_o, s0);
      do_reset();
      send({16'h7FFF, 18'h00000}, 1, 0, 1);
      wait_clk(60);
      cmp_sample(sin_o, 16'sh0000);
      cmp_flag(cos_o[15], 1'b0);
      send({16'h8001, 18'h00000}, 1, 0, 1);
      wait_clk(60);
      cmp_flag(cos_o[15], 1'b1);
      // Low 18 bits land on top: 2^32 step, 4-cycle period
      send({16'h7FFF, 18'h10000}, 1, 0, 1);
      wait_clk(60);
      s0 = sin_o;
      wait_clk(1);
      cmp_flag(sin_o != s0, 1'b1);
      wait_clk(3);
      cmp_sample(sin_o, s0);
      send({16'h0000, 18'h10000}, 1, 0, 1);
      wait_clk(90);
      cmp_sample(cos_o, 16'sh0000);
      conclude();
   end
endmodule : quadrature_nco_modulator_tb
`default_nettype wire
